// ==== bec_regs.svh ====
// Register offsets, field layout and timing counts of the event capture block
// Assumes a 40 MHz system clock and a 5 MHz sampled link clock
`ifndef BEC_REGS_SVH
`define BEC_REGS_SVH

`define BEC_OFF_CTRL 12'h000
`define BEC_OFF_STATUS 12'h004
`define BEC_OFF_COUNT 12'h008
`define BEC_OFF_DATA 12'h00C

`define BEC_CTRL_CLEAR 0
`define BEC_CTRL_ENABLE 1
`define BEC_CTRL_RESET 32'h0000_0002

`define BEC_STAT_EMPTY 0
`define BEC_STAT_FULL 1
`define BEC_STAT_TIMING 2

`define BEC_WORD_BITS 16
`define BEC_ENERGY_BITS 11
`define BEC_TAG_BITS 5
`define BEC_TAG_FIRST 5'h1F
`define BEC_TAG_NEXT 5'h1E
`define BEC_TAG_LAST 5'h00

`define BEC_LINK_PERIOD_NS 200
`define BEC_CLK_PERIOD_NS 25
`define BEC_LINK_CYCLES (`BEC_LINK_PERIOD_NS / `BEC_CLK_PERIOD_NS)

`endif

// ==== bec_pkg.sv ====
// Types shared by the event capture block
// Assumes bec_regs.svh for widths
`include "bec_regs.svh"
package bec_pkg;
  typedef struct packed {
    logic clock;
    logic strobe;
    logic serial;
    logic timing;
  } bec_link_t;

  typedef struct packed {
    logic [`BEC_TAG_BITS-1:0] tag;
    logic [`BEC_ENERGY_BITS-1:0] energy;
  } bec_word_t;

  typedef enum logic [1:0] {
    BEC_WAIT_TIMING,
    BEC_WAIT_DATA,
    BEC_IN_EVENT
  } bec_evt_state_t;
endpackage : bec_pkg

// ==== bec_capture.sv ====
// Burst event capture: serial link receiver, event store, event counter
// Assumes an APB master on clk and a front-end driving the link pins
//
// Operation
// RULE_01: Sender supplies 200 ns link clock
// RULE_02: Link clock runs before timing, after data
// RULE_03: Timing pulse lasts six link periods
// RULE_04: One timing pulse precedes each event
// RULE_05: Strobe and data follow timing by 4 us
// RULE_06: Counter decrements on reads, link clocked
// RULE_07: Counter increments per complete stored event; code also counts events dropped while the store is full
// RULE_08: Empty flag clears on first write
// RULE_09: Bar is two words, side A then B
// RULE_10: Tag 1F first, 1E next, 0 last
// RULE_11: Word is 5-bit tag, 11-bit energy
// RULE_12: First single-bar event after clear counts
// RULE_13: Sample data under strobe, write per word
`timescale 1ns/1ps
`default_nettype none
`include "bec_regs.svh"
module bec_capture #(
  parameter int DEPTH = 64,
  parameter int CNT_BITS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire bec_pkg::bec_link_t link_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic event_store_write,
  output logic fifo_empty
);
  import bec_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Link synchronisers
  // ----------------------------------------------------------------
  bec_link_t meta_ff, sync_ff, prev_ff;
  logic link_rise;
  logic timing_rise;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= link_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign link_rise = sync_ff.clock & ~prev_ff.clock;
  assign timing_rise = sync_ff.timing & ~prev_ff.timing;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  logic apb_acc;
  logic wr_ctrl;
  logic rd_data;
  assign apb_acc = psel & penable;
  assign wr_ctrl = apb_acc & pwrite & hit(paddr, `BEC_OFF_CTRL);
  assign rd_data = apb_acc & ~pwrite & hit(paddr, `BEC_OFF_DATA);
  assign pready = 1'b1;

  logic [31:0] ctrl_ff, nxt_ctrl;
  logic clear_req;
  assign clear_req = wr_ctrl & pwdata[`BEC_CTRL_CLEAR];

  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = {30'h0000_0000, pwdata[`BEC_CTRL_ENABLE], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= `BEC_CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Serial word receiver
  // ----------------------------------------------------------------
  logic [`BEC_WORD_BITS-1:0] shift_ff, nxt_shift;
  logic [4:0] bits_ff, nxt_bits;
  logic word_done;
  bec_word_t word;

  always_comb begin
    nxt_shift = shift_ff;
    nxt_bits = bits_ff;
    word_done = 1'b0;
    if (!sync_ff.strobe) begin
      nxt_bits = 5'h00;
    end else if (link_rise) begin // [RULE_13]
      nxt_shift = {shift_ff[`BEC_WORD_BITS-2:0], sync_ff.serial}; // [RULE_11]
      if (bits_ff == 5'(`BEC_WORD_BITS - 1)) begin
        nxt_bits = 5'h00;
        word_done = ctrl_ff[`BEC_CTRL_ENABLE];
      end else begin
        nxt_bits = bits_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      shift_ff <= '0;
      bits_ff <= '0;
    end else begin
      shift_ff <= nxt_shift;
      bits_ff <= nxt_bits;
    end
  end

  assign word = bec_word_t'(nxt_shift);

  // ----------------------------------------------------------------
  // Event framing
  // ----------------------------------------------------------------
  bec_evt_state_t st_ff, nxt_st;
  logic half_ff, nxt_half;
  logic last_ff, nxt_last;
  logic event_done;

  always_comb begin
    nxt_st = st_ff;
    nxt_half = half_ff;
    nxt_last = last_ff;
    event_done = 1'b0;
    if (timing_rise) begin // [RULE_04]
      nxt_st = BEC_WAIT_DATA;
      nxt_half = 1'b0;
    end else if (word_done) begin
      nxt_half = ~half_ff; // [RULE_09]
      if (!half_ff) begin
        nxt_last = (word.tag == `BEC_TAG_LAST); // [RULE_10]
        nxt_st = BEC_IN_EVENT;
      end else if (last_ff) begin
        event_done = 1'b1; // [RULE_07]
        nxt_st = BEC_WAIT_TIMING;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= BEC_WAIT_TIMING;
      half_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      half_ff <= nxt_half;
      last_ff <= nxt_last;
    end
  end

  // ----------------------------------------------------------------
  // Event store
  // ----------------------------------------------------------------
  logic [`BEC_WORD_BITS-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [AW:0] used_ff, nxt_used;
  logic do_wr, do_rd;
  logic [31:0] rdata_ff, nxt_rdata;

  assign do_wr = word_done & (used_ff != (AW+1)'(DEPTH));
  assign do_rd = rd_data & (used_ff != '0);
  assign event_store_write = do_wr; // [RULE_13]

  always_comb begin
    nxt_wp = do_wr ? wp_ff + AW'(1) : wp_ff;
    nxt_rp = do_rd ? rp_ff + AW'(1) : rp_ff;
    nxt_used = used_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    if (clear_req) begin
      nxt_wp = '0;
      nxt_rp = '0;
      nxt_used = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      used_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      used_ff <= nxt_used;
    end
  end

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_ff[wp_ff] <= nxt_shift;
    end
  end

  assign fifo_empty = (used_ff == '0); // [RULE_08]

  // ----------------------------------------------------------------
  // Event counter
  // ----------------------------------------------------------------
  logic [CNT_BITS-1:0] cnt_ff, nxt_cnt;
  logic dec_pend_ff, nxt_dec_pend;
  logic dec_now;
  logic rd_evt_end;

  // Read of side-B word whose side-A word has the tag-last mark ends an event
  assign rd_evt_end = do_rd & rp_ff[0] &
    (mem_ff[rp_ff - AW'(1)][`BEC_WORD_BITS-1 -: `BEC_TAG_BITS]
      == `BEC_TAG_LAST);

  always_comb begin
    nxt_dec_pend = dec_pend_ff | rd_evt_end;
    dec_now = dec_pend_ff & link_rise; // [RULE_06]
    if (dec_now) begin
      nxt_dec_pend = rd_evt_end;
    end
    // Every complete event counts, first single-bar one too
    nxt_cnt = cnt_ff + CNT_BITS'(event_done) - CNT_BITS'(dec_now); // [RULE_12]
    if (clear_req) begin
      nxt_cnt = '0;
      nxt_dec_pend = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
      dec_pend_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      dec_pend_ff <= nxt_dec_pend;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdata = rdata_ff;
    pslverr = 1'b0;
    if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        `BEC_OFF_CTRL: nxt_rdata = ctrl_ff;
        `BEC_OFF_STATUS: nxt_rdata = {29'h0000_0000, sync_ff.timing,
          (used_ff == (AW+1)'(DEPTH)), fifo_empty};
        `BEC_OFF_COUNT: nxt_rdata = 32'(cnt_ff);
        `BEC_OFF_DATA: nxt_rdata = 32'(mem_ff[rp_ff]);
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    if (apb_acc && !(hit(paddr, `BEC_OFF_CTRL) ||
        hit(paddr, `BEC_OFF_STATUS) || hit(paddr, `BEC_OFF_COUNT) ||
        hit(paddr, `BEC_OFF_DATA))) begin
      pslverr = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata = rdata_ff;
endmodule : bec_capture
`default_nettype wire

// ==== bec_chk.sv ====
// Port checker for the event capture block
// Assumes it is bound into every bec_capture instance
`timescale 1ns/1ps
`default_nettype none
module bec_chk #(
  parameter int DEPTH = 64,
  parameter int CNT_BITS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire bec_pkg::bec_link_t link_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic event_store_write,
  input wire logic fifo_empty
);
  import bec_pkg::*;
  wire acc = psel && penable;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rst_idle;
    $fell(rst) |-> fifo_empty && !event_store_write;
  endproperty
  property p_wr_gap;
    event_store_write |=> !event_store_write [*8];
  endproperty
  property p_wr_fill;
    event_store_write && !(acc && pwrite) |=> !fifo_empty;
  endproperty
  property p_empty_fall;
    $fell(fifo_empty) |-> $past(event_store_write);
  endproperty
  property p_empty_rise;
    $rose(fifo_empty) |-> $past(acc);
  endproperty
  property p_err;
    acc && paddr > 12'h00C |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_no_err;
    !acc |-> !pslverr;
  endproperty
  property p_ready;
    acc |-> pready;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy after reset");
  a_wr_gap: assert property (p_wr_gap) else $error("write too soon");
  a_wr_fill: assert property (p_wr_fill) else $error("empty kept");
  a_empty_fall: assert property (p_empty_fall) else $error("bad fall");
  a_empty_rise: assert property (p_empty_rise) else $error("bad rise");
  a_err: assert property (p_err) else $error("unmapped accepted");
  a_no_err: assert property (p_no_err) else $error("stray error");
  a_ready: assert property (p_ready) else $error("no ready");
  c_write: cover property (event_store_write);
  c_err: cover property (pslverr);
  c_empty: cover property ($rose(fifo_empty));
endmodule : bec_chk
bind bec_capture bec_chk #(.DEPTH(DEPTH), .CNT_BITS(CNT_BITS)) u_chk (
  .clk(clk), .rst(rst), .link_in(link_in), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .event_store_write(event_store_write), .fifo_empty(fifo_empty));
`default_nettype wire

// ==== bec_fe_model.sv ====
// Front-end transmitter model driving the serial link
// Assumes tasks are called from the bench one at a time
`timescale 1ns/1ps
`default_nettype none
module bec_fe_model (
  output var bec_pkg::bec_link_t link
);
  import bec_pkg::*;
  initial link = '0;
  always #100 link.clock = ~link.clock;
  task automatic event_start();
    @(negedge link.clock);
    link.timing = 1'b1;
    repeat (6) @(negedge link.clock);
    link.timing = 1'b0;
    repeat (20) @(negedge link.clock);
  endtask : event_start
  task automatic send_word(input logic [15:0] w);
    link.strobe = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      link.serial = w[i];
      @(negedge link.clock);
    end
    link.strobe = 1'b0;
    link.serial = ~w[0];
    @(negedge link.clock);
  endtask : send_word
endmodule : bec_fe_model
`default_nettype wire

// ==== burst_event_capture_tb.sv ====
// Bench for the event capture block
// Assumes bec_capture, bec_chk and bec_fe_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module burst_event_capture_tb;
  import bec_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, event_store_write, fifo_empty, e;
  bec_link_t link;
  int miscompares = 0, n_checks = 0, nwr = 0, cyc = 0;
  logic [19:0] w3 [6] = '{20'h1F4B0, 20'h0530C, 20'h1E208, 20'h0B28A,
                          20'h00B22, 20'h02898};
  bec_fe_model fe (.link(link));
  bec_capture uut (.clk(clk), .rst(rst), .link_in(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_store_write(event_store_write), .fifo_empty(fifo_empty));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (event_store_write === 1'b1) nwr++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task automatic wait_wr(input int n);
    for (int i = 0; i < 400 && nwr < n; i++) @(posedge clk);
    chk(32'(nwr), 32'(n));
  endtask : wait_wr
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // ----
  // Tests
  // ----
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(12'h004, 32'h1);
    rd(12'h008, 32'h0);
    chk({31'h0, fifo_empty}, 32'h1);
    $display("reset test done");
    fe.event_start();
    fe.send_word(16'h0001);
    fe.send_word(16'h8001);
    wait_wr(2);
    rd(12'h008, 32'h1);
    rd(12'h004, 32'h0);
    chk({31'h0, fifo_empty}, 32'h0);
    fe.event_start();
    for (int i = 0; i < 6; i++) begin
      fe.send_word({w3[i][16:12], w3[i][10:0]});
      if (i == 1) wait_wr(4);
      if (i == 1) rd(12'h008, 32'h1);
    end
    wait_wr(8);
    rd(12'h008, 32'h2);
    $display("capture test done");
    rd(12'h00C, 32'h0001);
    rd(12'h00C, 32'h8001);
    repeat (16) @(posedge clk);
    rd(12'h008, 32'h1);
    foreach (w3[i]) rd(12'h00C, {16'h0, w3[i][16:12], w3[i][10:0]});
    repeat (16) @(posedge clk);
    rd(12'h008, 32'h0);
    rd(12'h004, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("readout test done");
    fe.event_start();
    fe.send_word(16'h0001);
    fe.send_word(16'h8003);
    wait_wr(10);
    apb(1'b1, 12'h000, 32'h3);
    rd(12'h008, 32'h0);
    rd(12'h004, 32'h1);
    chk({31'h0, fifo_empty}, 32'h1);
    fe.event_start();
    fe.send_word(16'h0001);
    fe.send_word(16'h8001);
    wait_wr(12);
    rd(12'h008, 32'h1);
    $display("clear test done");
    // Capture disabled: no word stored, no event counted
    apb(1'b1, 12'h000, 32'h0);
    fe.event_start();
    fe.send_word(16'h0001);
    fe.send_word(16'h8001);
    wait_wr(12);
    rd(12'h008, 32'h1);
    apb(1'b1, 12'h000, 32'h2);
    $display("enable test done");
    summarize();
  end
endmodule : burst_event_capture_tb
`default_nettype wire
